// ---- hdl/fpsg_defs.svh ----
/*
  Offsets, field positions, reset values and fixed layout of the flash
  password security gate.
  Assumes a 32-bit word bus with byte addresses and two zones.
*/
`ifndef FPSG_DEFS_SVH
`define FPSG_DEFS_SVH

`define FPSG_ZONE1_BASE      32'hFFFFF700
`define FPSG_ZONE2_BASE      32'hFFFFF600
`define FPSG_ZONE_SPAN_MASK  32'hFFFFFF00
`define FPSG_KEY_OFS0        8'h00
`define FPSG_KEY_OFS3        8'h0C
`define FPSG_SCR_OFS         8'h24
`define FPSG_IRQ_STAT_OFS    8'h28
`define FPSG_IRQ_MASK_OFS    8'h2C
`define FPSG_PW_OFS0         8'h00
`define FPSG_PW_OFS3         8'h0C
`define FPSG_ZONE1_PW_WORDS_FROM_END 8
`define FPSG_ZONE2_PW_WORDS_FROM_END 4
`define FPSG_FORCE_BIT       31
`define FPSG_SEC_BIT         0
`define FPSG_KEY_RESET       32'h00000000
`define FPSG_PW_ERASED       128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF
`define FPSG_PW_LOCKED       128'h00000000000000000000000000000000
`define FPSG_IRQ_UNSEC_BIT   0
`define FPSG_IRQ_SECURE_BIT  1
`define FPSG_IRQ_DENY_BIT    2
`define FPSG_IRQ_ILLEGAL_BIT 3

`endif

// ---- hdl/fpsg_pkg.sv ----
/*
  Types shared by the gate and its zone units.
  Assumes fpsg_defs.svh holds the numbers.
*/
package fpsg_pkg;
  typedef logic [31:0]  fpsg_word_type;
  typedef logic [127:0] fpsg_pw_type;
  typedef enum logic [1:0] {
    FPSG_EVAL_IDLE,
    FPSG_EVAL_RUN,
    FPSG_EVAL_DONE
  } fpsg_eval_type;
endpackage : fpsg_pkg

// ---- hdl/fpsg_key_bank.sv ----
/*
  Unlock key words of one zone: four privileged-write words, cleared by
  reset and by the force-secure strobe.
  Assumes strobes are one cycle and the caller decodes the zone.
*/
`timescale 1ns/100ps
`include "fpsg_defs.svh"
module fpsg_key_bank
  import fpsg_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         wr_in,
  input  wire logic [1:0]   idx_in,
  input  wire fpsg_word_type wdata_in,
  input  wire logic         clear_in,
  output fpsg_pw_type       key_out
);
  fpsg_word_type key_q [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_word
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          key_q[g] <= `FPSG_KEY_RESET;
        end else if (clear_in) begin
          key_q[g] <= `FPSG_KEY_RESET;
        end else if (wr_in && idx_in == 2'(g)) begin
          key_q[g] <= wdata_in;
        end
      end
      assign key_out[32*g +: 32] = key_q[g];
    end
  endgenerate
endmodule : fpsg_key_bank

// ---- hdl/fpsg_zone_eval.sv ----
/*
  Secure state of one zone: evaluated after every reset from the stored
  password, then kept by key match and force-secure.
  Assumes the stored password is stable while a reset is released.
*/
`timescale 1ns/100ps
`include "fpsg_defs.svh"
module fpsg_zone_eval
  import fpsg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire fpsg_pw_type pw_in,
  input  wire fpsg_pw_type key_in,
  input  wire logic        force_in,
  output logic             secure_out,
  output logic             locked_out
);
  fpsg_eval_type state_q;
  logic          sec_q;
  logic          lock_q;
  logic          match;

  // an all-zero password never unlocks, whatever the key holds
  assign match = (key_in == pw_in) && (pw_in != `FPSG_PW_LOCKED);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= FPSG_EVAL_IDLE;
    end else begin
      unique case (state_q)
        FPSG_EVAL_IDLE: state_q <= FPSG_EVAL_RUN;
        FPSG_EVAL_RUN:  state_q <= FPSG_EVAL_DONE;
        FPSG_EVAL_DONE: state_q <= FPSG_EVAL_DONE;
      endcase
    end
  end

  // the password is read only after release, never under reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_q  <= 1'b1;
      lock_q <= 1'b0;
    end else if (state_q == FPSG_EVAL_RUN) begin
      lock_q <= (pw_in == `FPSG_PW_LOCKED);
      sec_q  <= (pw_in != `FPSG_PW_ERASED);
    end else if (state_q == FPSG_EVAL_DONE) begin
      if (force_in || lock_q) begin
        sec_q <= 1'b1;
      end else if (match) begin
        sec_q <= 1'b0;
      end
    end
  end

  assign secure_out = sec_q;
  assign locked_out = lock_q;

  zero_pw_locks_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    lock_q |-> sec_q) else $error("locked zone reads unsecured");
  force_secures_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (force_in && state_q == FPSG_EVAL_DONE) |=> sec_q)
    else $error("force did not secure");
endmodule : fpsg_zone_eval

// ---- hdl/fpsg_gate.sv ----
/*
  Flash password security gate: two zones with key registers, status and
  control, stored password words in flash, and a data-access filter.
  Assumes a single-cycle register port, flash storage modelled in
  flip-flops, and a processor that marks privileged and fetched-from-secure.
*/
// Summary of operation
// - password is four words, low first
// - zone one words end eight words early
// - zone two words end four words early
// - password writes checked like secure flash
// - password reads masked while secured
// - all ones password leaves device unsecured
// - all zeros password locks device forever
// - password evaluated at every reset
// - secure data only from secure code while its zone is secured
// - code may move between memories freely
// - absent module answers with illegal access
// - zone bases FFFFF700 and FFFFF600
// - four privileged key words, reset zero
// - force bit clears keys, secures, reads zero
// - status bit zero shows secure, resets one
`timescale 1ns/100ps
`include "fpsg_defs.svh"
module fpsg_gate
  import fpsg_pkg::*;
#(
  parameter logic        MODULE_PRESENT = 1'b1,
  parameter logic [31:0] FLASH_SECTOR1_END = 32'h00002000,
  parameter logic [31:0] FLASH_ZONE2_SECTOR_END = 32'h00042000
)(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [31:0]   addr_in,
  input  wire fpsg_word_type wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  input  wire logic          priv_in,
  input  wire logic          fetch_secure_in,
  input  wire logic          data_req_in,
  input  wire logic          data_secure_in,
  input  wire logic          data_zone_in,
  output fpsg_word_type      rdata_out,
  output logic               illegal_out,
  output logic               data_grant_out,
  output logic               data_deny_out,
  output logic [1:0]         secure_out,
  output logic               irq_out
);
  localparam logic [31:0] PW1_BASE =
    FLASH_SECTOR1_END - 32'(`FPSG_ZONE1_PW_WORDS_FROM_END * 4);
  localparam logic [31:0] PW2_BASE =
    FLASH_ZONE2_SECTOR_END - 32'(`FPSG_ZONE2_PW_WORDS_FROM_END * 4);

  fpsg_word_type pw_q [2][4];
  fpsg_pw_type   pw_flat [2];
  fpsg_pw_type   key_flat [2];
  logic [1:0]    sec;
  logic [1:0]    lock;
  logic [1:0]    reg_hit;
  logic [1:0]    pw_hit;
  logic [1:0]    key_wr;
  logic [1:0]    force_wr;
  logic [7:0]    ofs;
  logic [3:0]    irq_stat_q;
  logic [3:0]    irq_mask_q;
  logic [3:0]    irq_evt;
  logic [1:0]    sec_prev_q;
  logic          pw_wr_ok;
  logic          illegal_evt;
  logic          deny_evt;
  fpsg_word_type rdata_d;
  fpsg_word_type rdata_q;
  logic          illegal_q;

  assign ofs = addr_in[7:0];

  genvar z;
  generate
    for (z = 0; z < 2; z++) begin : g_zone
      assign reg_hit[z] = (addr_in & `FPSG_ZONE_SPAN_MASK) ==
        (z == 0 ? `FPSG_ZONE1_BASE : `FPSG_ZONE2_BASE);
      assign pw_hit[z] = (addr_in[31:4] ==
        (z == 0 ? PW1_BASE[31:4] : PW2_BASE[31:4]));
      assign key_wr[z] = MODULE_PRESENT && wr_in && priv_in && reg_hit[z] &&
        ofs <= `FPSG_KEY_OFS3 && ofs[1:0] == 2'h0;
      assign force_wr[z] = MODULE_PRESENT && wr_in && priv_in &&
        reg_hit[z] && ofs == `FPSG_SCR_OFS &&
        wdata_in[`FPSG_FORCE_BIT];
      // low word at the lowest offset
      assign pw_flat[z] = {pw_q[z][3], pw_q[z][2],
                           pw_q[z][1], pw_q[z][0]};

      fpsg_key_bank u_keys (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .wr_in    (key_wr[z]),
        .idx_in   (ofs[3:2]),
        .wdata_in (wdata_in),
        .clear_in (force_wr[z]),
        .key_out  (key_flat[z])
      );

      fpsg_zone_eval u_eval (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .pw_in      (pw_flat[z]),
        .key_in     (key_flat[z]),
        .force_in   (force_wr[z]),
        .secure_out (sec[z]),
        .locked_out (lock[z])
      );

      // flash contents survive reset: no reset branch here
      for (genvar w = 0; w < 4; w++) begin : g_word
        always_ff @(posedge clk_in) begin
          if (wr_in && pw_hit[z] && addr_in[3:2] == 2'(w) && pw_wr_ok) begin
            pw_q[z][w] <= wdata_in;
          end
        end
      end
    end
  endgenerate

  // same check as any secured flash word: unsecured, or code from secure
  always_comb begin
    pw_wr_ok = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (pw_hit[i]) begin
        pw_wr_ok = !sec[i] || fetch_secure_in;
      end
    end
  end

  // data filter; fetch origin, data security and zone state decide, so code may cross freely
  always_comb begin
    data_grant_out = data_req_in;
    if (data_secure_in && sec[data_zone_in] && !fetch_secure_in) begin
      data_grant_out = 1'b0;
    end
  end
  assign deny_evt = data_req_in && !data_grant_out;
  assign data_deny_out = deny_evt;

  assign illegal_evt = !MODULE_PRESENT && (wr_in || rd_in) &&
    (reg_hit != 2'b00);

  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < 2; i++) begin
      if (reg_hit[i] && MODULE_PRESENT) begin
        if (ofs <= `FPSG_KEY_OFS3 && ofs[1:0] == 2'h0) begin
          rdata_d = key_flat[i][32*ofs[3:2] +: 32];
        end else if (ofs == `FPSG_SCR_OFS) begin
          rdata_d[`FPSG_SEC_BIT] = sec[i];
        end else if (ofs == `FPSG_IRQ_STAT_OFS && i == 0) begin
          rdata_d = {28'h0000000, irq_stat_q};
        end else if (ofs == `FPSG_IRQ_MASK_OFS && i == 0) begin
          rdata_d = {28'h0000000, irq_mask_q};
        end
      end
      if (pw_hit[i] && !sec[i]) begin
        rdata_d = pw_q[i][addr_in[3:2]];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q   <= 32'h00000000;
      illegal_q <= 1'b0;
    end else begin
      rdata_q   <= rd_in ? rdata_d : 32'h00000000;
      illegal_q <= illegal_evt;
    end
  end
  assign rdata_out   = rdata_q;
  assign illegal_out = illegal_q;
  assign secure_out  = sec;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_prev_q <= 2'b11;
    end else begin
      sec_prev_q <= sec;
    end
  end

  assign irq_evt[`FPSG_IRQ_UNSEC_BIT]   = |(sec_prev_q & ~sec);
  assign irq_evt[`FPSG_IRQ_SECURE_BIT]  = |(~sec_prev_q & sec);
  assign irq_evt[`FPSG_IRQ_DENY_BIT]    = deny_evt;
  assign irq_evt[`FPSG_IRQ_ILLEGAL_BIT] = illegal_evt;

  // status lives in zone one's window; a read clears, a new event wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= 4'h0;
    end else if (rd_in && reg_hit[0] && ofs == `FPSG_IRQ_STAT_OFS) begin
      irq_stat_q <= irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= 4'h0;
    end else if (wr_in && reg_hit[0] && ofs == `FPSG_IRQ_MASK_OFS) begin
      irq_mask_q <= wdata_in[3:0];
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  sequence key_write_s;
    MODULE_PRESENT && wr_in && priv_in && reg_hit[0] && ofs == 8'h00;
  endsequence

  secure_data_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (data_req_in && data_secure_in && sec[data_zone_in] && !fetch_secure_in)
    |-> (!data_grant_out && data_deny_out))
    else $error("secure data leaked");
  pw_read_mask_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rd_in && pw_hit[0] && sec[0]) |=> rdata_out == 32'h00000000)
    else $error("password readable while secured");
  force_reads_zero_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (rd_in && reg_hit[0] && ofs == `FPSG_SCR_OFS) |=> !rdata_out[31])
    else $error("force bit read back");
  key_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    key_write_s ##1 (rd_in && reg_hit[0] && ofs == 8'h00 && !wr_in)
    |=> rdata_out == $past(wdata_in, 2))
    else $error("key word not stored");
  force_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    force_wr[0] |=> key_flat[0] == `FPSG_PW_LOCKED && sec[0])
    else $error("force did not clear keys");
  illegal_hit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    illegal_evt |=> illegal_out) else $error("illegal access missed");
  status_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (MODULE_PRESENT && rd_in && reg_hit[1] && ofs == `FPSG_SCR_OFS) |=>
    rdata_out[0] == $past(sec[1])) else $error("status bit wrong");
  fetch_free_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (data_req_in && !data_secure_in) |-> data_grant_out)
    else $error("plain data blocked");
endmodule : fpsg_gate

// ---- bench/fpsg_cpu_model.sv ----
/*
  Processor-side model that issues register and flash word accesses.
  Assumes the gate answers a read in the cycle after the strobe.
*/
`timescale 1ns/100ps
module fpsg_cpu_model
  import fpsg_pkg::*;
(
  input  wire logic          clk_in,
  input  wire fpsg_word_type rdata_in,
  output logic [31:0]        addr_out,
  output fpsg_word_type      wdata_out,
  output logic               wr_out,
  output logic               rd_out
);
  initial begin
    addr_out  = 32'h00000000;
    wdata_out = 32'h00000000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // released lines carry the inverse so a stale value is never trusted
  task automatic wr(input logic [31:0] a, input fpsg_word_type v);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= v;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~v;
  endtask : wr

  task automatic rd(input logic [31:0] a, output fpsg_word_type v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    v = rdata_in;
  endtask : rd

  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [31:0] a, input fpsg_word_type v,
                       output fpsg_word_type r);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= v;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~v;
    rd_out    <= 1'b1;
    @(posedge clk_in);
    rd_out    <= 1'b0;
    addr_out  <= ~a;
    #1;
    r = rdata_in;
  endtask : wr_rd
endmodule : fpsg_cpu_model

// ---- bench/fpsg_gate_test.sv ----
/*
  Self-checking bench of the flash password security gate.
  Assumes the processor model drives the register port.
*/
`timescale 1ns/100ps
`include "fpsg_defs.svh"
module fpsg_gate_test
  import fpsg_pkg::*;
;
  localparam logic [31:0] Z1 = `FPSG_ZONE1_BASE;
  localparam logic [31:0] Z2 = `FPSG_ZONE2_BASE;
  localparam logic [31:0] P1 = 32'h00001FE0;
  localparam logic [31:0] P2 = 32'h00041FF0;
  localparam fpsg_pw_type PW = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic          clk_in;
  logic          rst_n_in;
  logic [31:0]   addr;
  fpsg_word_type wdata;
  fpsg_word_type rdata;
  fpsg_word_type d;
  logic          wr, rd, priv, fetch, dreq, dsec, dzone;
  logic          illegal, grant, deny, irq;
  logic [1:0]    sec;
  fpsg_word_type rdata_nm;
  logic          illegal_nm;
  int            mismatches;
  int            n_tests;

  fpsg_gate #(
    .MODULE_PRESENT        (1'b1),
    .FLASH_SECTOR1_END     (32'h00002000),
    .FLASH_ZONE2_SECTOR_END(32'h00042000)
  ) i_fpsg_gate (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .priv_in(priv),
    .fetch_secure_in(fetch), .data_req_in(dreq),
    .data_secure_in(dsec), .data_zone_in(dzone), .rdata_out(rdata),
    .illegal_out(illegal), .data_grant_out(grant),
    .data_deny_out(deny), .secure_out(sec), .irq_out(irq)
  );

  // same bus on a variant without the module: register hits are illegal
  fpsg_gate #(
    .MODULE_PRESENT        (1'b0),
    .FLASH_SECTOR1_END     (32'h00002000),
    .FLASH_ZONE2_SECTOR_END(32'h00042000)
  ) i_fpsg_gate_absent (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .priv_in(priv),
    .fetch_secure_in(fetch), .data_req_in(dreq),
    .data_secure_in(dsec), .data_zone_in(dzone), .rdata_out(rdata_nm),
    .illegal_out(illegal_nm), .data_grant_out(),
    .data_deny_out(), .secure_out(), .irq_out()
  );

  fpsg_cpu_model i_fpsg_cpu_model (
    .clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
  );

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({30'h0, sec}, 32'h3);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : do_reset

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    i_fpsg_cpu_model.rd(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic wr4(input logic [31:0] base, input fpsg_pw_type v);
    for (int i = 0; i < 4; i++) begin
      i_fpsg_cpu_model.wr(base + 32'(4 * i), v[32*i +: 32]);
    end
  endtask : wr4

  task automatic chk4(input logic [31:0] base, input fpsg_pw_type v);
    for (int i = 0; i < 4; i++) begin
      rd_chk(base + 32'(4 * i), v[32*i +: 32]);
    end
  endtask : chk4

  // secure-memory data request from a given fetch origin and zone
  task automatic data_chk(input logic f, input logic z, input logic g);
    @(posedge clk_in);
    dreq  <= 1'b1;
    fetch <= f;
    dzone <= z;
    #1;
    check({31'h0, grant}, {31'h0, g});
    check({31'h0, deny}, {31'h0, ~g});
    @(posedge clk_in);
    dreq  <= 1'b0;
    fetch <= 1'b1;
  endtask : data_chk

  task automatic step_chk(input logic [1:0] exp);
    @(posedge clk_in);
    #1;
    check({30'h0, sec}, {30'h0, exp});
  endtask : step_chk

  initial begin
    #(4 * 20000);
    mismatches++;
    test_done();
  end

  initial begin
    rst_n_in   = 1'b0;
    priv       = 1'b1;
    fetch      = 1'b1;
    dreq       = 1'b0;
    dsec       = 1'b1;
    dzone      = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    // flash has no reset, so the passwords are stored before evaluation
    do_reset();
    wr4(P1, PW);
    wr4(P2, `FPSG_PW_ERASED);
    do_reset();
    check({30'h0, sec}, 32'h1);
    rd_chk(Z1 + 32'h24, 32'h1);
    check({31'h0, illegal_nm}, 32'h1);
    check(rdata_nm, 32'h0);
    check({31'h0, illegal}, 32'h0);
    rd_chk(Z2 + 32'h24, 32'h0);
    chk4(Z1, 128'h0);
    chk4(P2, `FPSG_PW_ERASED);
    rd_chk(P1, 32'h0);
    check({31'h0, illegal_nm}, 32'h0);
    rd_chk(Z1 + 32'h10, 32'h0);
    $display("test reset_eval done");
    data_chk(1'b0, 1'b0, 1'b0);
    data_chk(1'b1, 1'b0, 1'b1);
    data_chk(1'b0, 1'b1, 1'b1);
    $display("test data_filter done");
    i_fpsg_cpu_model.wr(Z1 + 32'h2C, 32'h00000001);
    // unsecure event from reset and one deny are pending: clear them first
    i_fpsg_cpu_model.rd(Z1 + 32'h28, d);
    check(d, 32'h5);
    check({31'h0, irq}, 32'h0);
    priv <= 1'b0;
    wr4(Z1, PW);
    chk4(Z1, 128'h0);
    fetch <= 1'b0;
    i_fpsg_cpu_model.wr(P1, 32'h00000000);
    priv <= 1'b1;
    i_fpsg_cpu_model.wr_rd(Z1, PW[31:0], d);
    check(d, PW[31:0]);
    wr4(Z1, PW);
    step_chk(2'b00);
    fetch <= 1'b1;
    chk4(Z1, PW);
    chk4(P1, PW);
    check({31'h0, irq}, 32'h1);
    i_fpsg_cpu_model.rd(Z1 + 32'h28, d);
    check(d & 32'h1, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("test unlock done");
    i_fpsg_cpu_model.wr(Z1 + 32'h24, 32'h80000000);
    step_chk(2'b01);
    chk4(Z1, 128'h0);
    rd_chk(Z1 + 32'h24, 32'h1);
    $display("test force_secure done");
    wr4(P1, `FPSG_PW_LOCKED);
    do_reset();
    wr4(Z1, `FPSG_PW_LOCKED);
    step_chk(2'b01);
    $display("test locked done");
    test_done();
  end
endmodule : fpsg_gate_test
